// File: design/flshc_top.sv
// Purpose: AXI4-Lite driven host controller for a parallel command flash
// Assumes: supplyGood and flash data synchronous to core_clk
// Notes: one flash operation at a time; orders while busy are refused
`timescale 1ns/1ps
// Notes on behaviour
// - after 70h read status, poll until ready (the read status op reads once; only otp program polls, without 70h)
// - otp program: c0h then data at target
// - clear status before retrying after an error
// - aborted operation must be reissued whole
// - reset/power-down follows the supply good signal
// - write ffh afterwards to restore read array
module flshc_top import flshc_pkg::*; #(
  parameter int RST_LOW_CYC = RESET_LOW_CYC,
  parameter int RST_REC_CYC = RESET_REC_CYC
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic supplyGood,
  input wire logic [FL_DATA_W-1:0] flashDataIn,
  output flshc_pins_t flashPins,
  output logic resetPowerdownN,
  output logic irq
);
  if (RST_LOW_CYC < 1 || RST_REC_CYC < 1 || RST_LOW_CYC > 65535 || RST_REC_CYC > 65535) begin : g_chk
    $error("reset counts out of range");
  end
  typedef enum logic [2:0] {S_IDLE, S_CMD, S_DATA, S_STAT, S_FF, S_ARRAY, S_RST_LOW, S_RST_REC} flshc_state_t;
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic awHeld_ff, wHeld_ff; // write address / data taken
  logic [AXI_ADDR_W-1:0] awAddr_ff;
  logic [31:0] wData_ff;
  logic [3:0] wStrb_ff;
  logic regWrite; // both halves held, response free
  logic [FL_ADDR_W-1:0] addr_ff; // software target address
  logic [FL_DATA_W-1:0] wdata_ff; // software data word
  logic [7:0] flStatus_ff; // last flash status byte
  logic [FL_DATA_W-1:0] arrData_ff; // last array word
  logic [IRQ_W-1:0] irqStat_ff, irqMask_ff, irqSet, irqClr;
  logic errPend_ff; // error seen, clear status not yet issued
  flshc_state_t state_ff;
  flshc_op_t op_ff;
  logic issued_ff, cycStart_ff;
  logic [15:0] rstCnt_ff;
  logic cycDone;
  logic [FL_DATA_W-1:0] cycRdata;
  logic ctrlWrite, startOk;
  logic [7:0] cmdByte;
  logic busy;
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction
  // ----------------------------------------------------------------
  // AXI4-Lite write channels
  // ----------------------------------------------------------------
  assign regWrite = awHeld_ff && wHeld_ff && !s_axi_bvalid;
  // address and data taken in either order; ready returns after response
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      awHeld_ff <= 1'b0;
      wHeld_ff <= 1'b0;
      awAddr_ff <= '0;
      wData_ff <= 32'h0000_0000;
      wStrb_ff <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_ff <= 1'b1;
        awAddr_ff <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_ff <= 1'b1;
        wData_ff <= s_axi_wdata;
        wStrb_ff <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (regWrite) begin
        awHeld_ff <= 1'b0;
        wHeld_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awAddr_ff[4:2] > REG_IRQ_MASK[4:2]) ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end
  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  assign ctrlWrite = regWrite && awAddr_ff[4:2] == REG_CTRL[4:2] && wStrb_ff[0];
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      addr_ff <= '0;
      wdata_ff <= '0;
      irqMask_ff <= '0;
    end else if (regWrite) begin
      unique case (awAddr_ff[4:2])
        REG_ADDR[4:2]: addr_ff <= FL_ADDR_W'(merge(32'(addr_ff), wData_ff, wStrb_ff));
        REG_WDATA[4:2]: wdata_ff <= FL_DATA_W'(merge(32'(wdata_ff), wData_ff, wStrb_ff));
        REG_IRQ_MASK[4:2]: irqMask_ff <= IRQ_W'(merge(32'(irqMask_ff), wData_ff, wStrb_ff));
        default: ; // control and w1c status are written elsewhere; others read-only or unmapped
      endcase
    end
  end
  assign irqClr = (regWrite && awAddr_ff[4:2] == REG_IRQ_STAT[4:2] && wStrb_ff[0]) ? wData_ff[IRQ_W-1:0] : '0;
  // sticky events; a new event beats a clear in the same cycle
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      irqStat_ff <= '0;
      irq <= 1'b0;
    end else begin
      irqStat_ff <= (irqStat_ff & ~irqClr) | irqSet;
      irq <= |(((irqStat_ff & ~irqClr) | irqSet) & irqMask_ff);
    end
  end
  // read channel answers on the same edge that takes the address
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      unique case (s_axi_araddr[4:2])
        REG_CTRL[4:2]: s_axi_rdata <= {31'h0, busy};
        REG_ADDR[4:2]: s_axi_rdata <= 32'(addr_ff);
        REG_WDATA[4:2]: s_axi_rdata <= 32'(wdata_ff);
        REG_STATUS[4:2]: s_axi_rdata <= {21'h0, supplyGood, errPend_ff, busy, flStatus_ff};
        REG_RDATA[4:2]: s_axi_rdata <= 32'(arrData_ff);
        REG_IRQ_STAT[4:2]: s_axi_rdata <= 32'(irqStat_ff);
        REG_IRQ_MASK[4:2]: s_axi_rdata <= 32'(irqMask_ff);
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
  // ----------------------------------------------------------------
  // operation sequencer
  // ----------------------------------------------------------------
  assign busy = state_ff != S_IDLE;
  // a modify order after an error is refused until clear status
  assign startOk = ctrlWrite && !busy && supplyGood && wData_ff[2:0] >= OP_READ_ARRAY && wData_ff[2:0] <= OP_RESET
    && !(wData_ff[2:0] == OP_OTP_PROGRAM && errPend_ff);
  always_comb begin
    unique case (op_ff)
      OP_READ_STATUS: cmdByte = CMD_READ_STATUS;
      OP_CLEAR_STATUS: cmdByte = CMD_CLEAR_STATUS;
      OP_OTP_PROGRAM: cmdByte = CMD_OTP_SETUP;
      default: cmdByte = CMD_READ_ARRAY;
    endcase
    if (state_ff == S_FF) begin
      cmdByte = CMD_READ_ARRAY;
    end
    irqSet = '0;
    irqSet[EV_REFUSED] = ctrlWrite && !startOk;
    // supply loss mid-operation: software must redo the whole sequence
    irqSet[EV_ABORTED] = !supplyGood && busy && state_ff != S_RST_LOW && state_ff != S_RST_REC;
    irqSet[EV_DONE] = cycDone && (state_ff == S_ARRAY || state_ff == S_FF
      || (state_ff == S_CMD && op_ff == OP_CLEAR_STATUS)
      || (state_ff == S_STAT && op_ff == OP_READ_STATUS)) || (state_ff == S_RST_REC && rstCnt_ff == 16'h0000);
    irqSet[EV_ERROR] = cycDone && state_ff == S_STAT && cycRdata[ST_READY] && |(cycRdata[7:0] & ST_ERR_MASK);
  end
  always_ff @(posedge core_clk) begin
    cycStart_ff <= 1'b0;
    if (!reset_n) begin
      state_ff <= S_RST_LOW;
      op_ff <= OP_RESET;
      issued_ff <= 1'b0;
      rstCnt_ff <= 16'(RST_LOW_CYC - 1);
      resetPowerdownN <= 1'b0;
    end else if (!supplyGood) begin
      // hold the flash in reset while the supply is not good
      state_ff <= S_RST_LOW;
      issued_ff <= 1'b0;
      rstCnt_ff <= 16'(RST_LOW_CYC - 1);
      resetPowerdownN <= 1'b0;
    end else if (startOk) begin
      op_ff <= flshc_op_t'(wData_ff[2:0]);
      if (wData_ff[2:0] == OP_RESET) begin
        state_ff <= S_RST_LOW;
        rstCnt_ff <= 16'(RST_LOW_CYC - 1);
        resetPowerdownN <= 1'b0;
      end else begin
        state_ff <= S_CMD;
      end
    end else begin
      unique case (state_ff)
        S_IDLE: ;
        S_RST_LOW: begin
          if (rstCnt_ff == 16'h0000) begin
            state_ff <= S_RST_REC;
            rstCnt_ff <= 16'(RST_REC_CYC - 1);
            resetPowerdownN <= 1'b1;
          end else begin
            rstCnt_ff <= rstCnt_ff - 16'h0001;
          end
        end
        S_RST_REC: begin
          if (rstCnt_ff == 16'h0000) begin
            state_ff <= S_IDLE;
          end else begin
            rstCnt_ff <= rstCnt_ff - 16'h0001;
          end
        end
        default: begin
          // bus states: issue one cycle, wait for it, then move on
          if (!issued_ff) begin
            cycStart_ff <= 1'b1;
            issued_ff <= 1'b1;
          end else if (cycDone) begin
            issued_ff <= 1'b0;
            unique case (state_ff)
              S_CMD: begin
                unique case (op_ff)
                  OP_READ_STATUS: state_ff <= S_STAT;
                  OP_OTP_PROGRAM: state_ff <= S_DATA;
                  OP_READ_ARRAY: state_ff <= S_ARRAY;
                  default: state_ff <= S_IDLE;
                endcase
              end
              S_DATA: state_ff <= S_STAT;
              // otp program keeps reading status until the ready bit is one; read status reads once
              S_STAT: state_ff <= (op_ff != OP_OTP_PROGRAM) ? S_IDLE :
                (cycRdata[ST_READY] ? S_FF : S_STAT);
              default: state_ff <= S_IDLE;
            endcase
          end
        end
      endcase
    end
  end
  // captured flash state
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      flStatus_ff <= 8'h00;
      arrData_ff <= '0;
      errPend_ff <= 1'b0;
    end else if (cycDone && state_ff == S_STAT) begin
      flStatus_ff <= cycRdata[7:0];
      errPend_ff <= errPend_ff || (cycRdata[ST_READY] && |(cycRdata[7:0] & ST_ERR_MASK));
    end else if (cycDone && state_ff == S_ARRAY) begin
      arrData_ff <= cycRdata;
    end else if (cycDone && state_ff == S_CMD && op_ff == OP_CLEAR_STATUS) begin
      errPend_ff <= 1'b0;
    end
  end
  flshc_bus_cycle u_cycle (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .start(cycStart_ff),
    .isWrite(state_ff == S_CMD || state_ff == S_DATA || state_ff == S_FF),
    .abort(!supplyGood),
    .addr((state_ff == S_DATA || state_ff == S_ARRAY) ? addr_ff : '0),
    .wdata((state_ff == S_DATA) ? wdata_ff : {8'h00, cmdByte}),
    .dataIn(flashDataIn),
    .pins(flashPins),
    .done(cycDone),
    .rdata(cycRdata)
  );
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  setup_then_data_a: assert property (@(posedge core_clk) disable iff (!reset_n || !supplyGood)
    state_ff == S_CMD && op_ff == OP_OTP_PROGRAM && cycDone |=> state_ff == S_DATA)
    else $error("otp setup not followed by data write");
  poll_busy_a: assert property (@(posedge core_clk) disable iff (!reset_n || !supplyGood)
    state_ff == S_STAT && op_ff == OP_OTP_PROGRAM && cycDone && !cycRdata[ST_READY] |=> state_ff == S_STAT)
    else $error("polling stopped while busy");
  ready_exit_a: assert property (@(posedge core_clk) disable iff (!reset_n || !supplyGood)
    state_ff == S_STAT && op_ff == OP_OTP_PROGRAM && cycDone && cycRdata[ST_READY] |=> state_ff == S_FF)
    else $error("ready status not acted on");
  restore_read_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    cycStart_ff && state_ff == S_FF |=> flashPins.dataOut == FL_DATA_W'(CMD_READ_ARRAY))
    else $error("read array restore used wrong code");
  retry_blocked_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    ctrlWrite && !busy && errPend_ff && wData_ff[2:0] == OP_OTP_PROGRAM |=> !busy && irqStat_ff[EV_REFUSED])
    else $error("modify started with error pending");
  supply_reset_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    !supplyGood |=> !resetPowerdownN && flashPins.weN)
    else $error("flash not held in reset on supply loss");
  abort_flag_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    !supplyGood && (state_ff == S_DATA || state_ff == S_STAT) |=> irqStat_ff[EV_ABORTED] && state_ff == S_RST_LOW)
    else $error("aborted operation not reported");
endmodule

// File: design/flshc_pkg.sv
// Purpose: shared constants and types of the flash host controller
// Assumes: core_clk at 20 MHz, 16-bit flash data, 19-bit word address
// Notes: register map is the controller's own, reached over AXI4-Lite
package flshc_pkg;
  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50; // core_clk period
  localparam int SETUP_NS = 50; // address and chip select before strobe
  localparam int STROBE_NS = 120; // write pulse or read access time
  localparam int HOLD_NS = 50; // hold after strobe
  localparam int RESET_LOW_NS = 100000; // reset/power-down low time
  localparam int RESET_REC_NS = 1000; // recovery after reset release
  // least times round up
  localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_LOW_CYC = (RESET_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_REC_CYC = (RESET_REC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ----------------------------------------------------------------
  // flash bus
  // ----------------------------------------------------------------
  localparam int FL_ADDR_W = 19;
  localparam int FL_DATA_W = 16;
  localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_OTP_SETUP = 8'hc0;
  // flash status byte bit positions
  localparam int ST_READY = 7; // sequencer_ready_flag
  localparam int ST_ERASE_ERR = 5; // erase_unlock_error_flag
  localparam int ST_PROG_ERR = 4; // program_error_flag
  localparam int ST_SUPPLY_ERR = 3; // program_supply_error_flag
  localparam int ST_PROTECT = 1; // protect_detect_flag
  localparam logic [7:0] ST_ERR_MASK = 8'h3a;
  // pins driven toward the flash
  typedef struct packed {
    logic ceN;
    logic weN;
    logic oeN;
    logic [FL_ADDR_W-1:0] addr;
    logic [FL_DATA_W-1:0] dataOut;
    logic dataOe;
  } flshc_pins_t;
  // ----------------------------------------------------------------
  // register map (byte offsets)
  // ----------------------------------------------------------------
  localparam int AXI_ADDR_W = 5;
  localparam logic [4:0] REG_CTRL = 5'h00; // w: op code, r: busy
  localparam logic [4:0] REG_ADDR = 5'h04; // target word address
  localparam logic [4:0] REG_WDATA = 5'h08; // data word to program
  localparam logic [4:0] REG_STATUS = 5'h0c; // flash status and own state
  localparam logic [4:0] REG_RDATA = 5'h10; // last array word read
  localparam logic [4:0] REG_IRQ_STAT = 5'h14; // sticky events, w1c
  localparam logic [4:0] REG_IRQ_MASK = 5'h18; // event enables
  localparam int STS_BUSY = 8;
  localparam int STS_ERR_PEND = 9;
  localparam int STS_SUPPLY = 10;
  localparam int IRQ_W = 4;
  localparam int EV_DONE = 0;
  localparam int EV_ERROR = 1;
  localparam int EV_REFUSED = 2;
  localparam int EV_ABORTED = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // operations software can order
  typedef enum logic [2:0] {
    OP_READ_ARRAY = 3'h1,
    OP_READ_STATUS = 3'h2,
    OP_CLEAR_STATUS = 3'h3,
    OP_OTP_PROGRAM = 3'h4,
    OP_RESET = 3'h5
  } flshc_op_t;
endpackage

// File: design/flshc_bus_cycle.sv
// Purpose: one timed write or read cycle on the flash pins
// Assumes: flash data input synchronous to core_clk
// Notes: chip select is low only inside a cycle, so the flash idles in standby
`timescale 1ns/1ps
module flshc_bus_cycle import flshc_pkg::*; #(
  parameter int SU_CYC = SETUP_CYC,
  parameter int ST_CYC = STROBE_CYC,
  parameter int HO_CYC = HOLD_CYC
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic start, // one-cycle request
  input wire logic isWrite,
  input wire logic abort, // drop the cycle at once
  input wire logic [FL_ADDR_W-1:0] addr,
  input wire logic [FL_DATA_W-1:0] wdata,
  input wire logic [FL_DATA_W-1:0] dataIn,
  output flshc_pins_t pins,
  output logic done, // one-cycle pulse
  output logic [FL_DATA_W-1:0] rdata
);
  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (SU_CYC < 1 || ST_CYC < 1 || HO_CYC < 1 || SU_CYC > 256 || ST_CYC > 256 || HO_CYC > 256) begin : g_chk
    $error("bus cycle phase counts out of range");
  end
  typedef enum logic [1:0] {PH_IDLE, PH_SETUP, PH_STROBE, PH_HOLD} flshc_phase_t;
  flshc_phase_t phase_ff; // current phase
  logic [7:0] cnt_ff; // cycles left in phase
  logic wr_ff; // cycle kind
  // ----------------------------------------------------------------
  // phase sequencing and pins
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    done <= 1'b0;
    if (!reset_n || abort) begin
      phase_ff <= PH_IDLE;
      cnt_ff <= 8'h00;
      wr_ff <= 1'b0;
      pins <= '{ceN: 1'b1, weN: 1'b1, oeN: 1'b1, addr: '0, dataOut: '0, dataOe: 1'b0};
      rdata <= '0;
    end else begin
      unique case (phase_ff)
        PH_IDLE: begin
          if (start) begin
            // address, select and data first; strobe comes later
            phase_ff <= PH_SETUP;
            cnt_ff <= 8'(SU_CYC - 1);
            wr_ff <= isWrite;
            pins.ceN <= 1'b0;
            pins.addr <= addr;
            pins.dataOut <= wdata;
            pins.dataOe <= isWrite;
          end
        end
        PH_SETUP: begin
          if (cnt_ff == 8'h00) begin
            phase_ff <= PH_STROBE;
            cnt_ff <= 8'(ST_CYC - 1);
            pins.weN <= !wr_ff;
            pins.oeN <= wr_ff;
          end else begin
            cnt_ff <= cnt_ff - 8'h01;
          end
        end
        PH_STROBE: begin
          if (cnt_ff == 8'h00) begin
            // sample at the end of the access time
            phase_ff <= PH_HOLD;
            cnt_ff <= 8'(HO_CYC - 1);
            pins.weN <= 1'b1;
            pins.oeN <= 1'b1;
            if (!wr_ff) begin
              rdata <= dataIn;
            end
          end else begin
            cnt_ff <= cnt_ff - 8'h01;
          end
        end
        PH_HOLD: begin
          if (cnt_ff == 8'h00) begin
            // release the bus so other memories may use it
            phase_ff <= PH_IDLE;
            pins.ceN <= 1'b1;
            pins.dataOe <= 1'b0;
            done <= 1'b1;
          end else begin
            cnt_ff <= cnt_ff - 8'h01;
          end
        end
      endcase
    end
  end
  // a command write always has data driven under the write strobe
  cmd_data_driven_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    !pins.weN |-> pins.dataOe && !pins.ceN) else $error("write strobe without data");
endmodule

// File: tb/flshc_flash_model.sv
// Purpose: behavioural flash device facing the controller pins
// Assumes: pins move on core_clk, so the model samples them there
// Notes: failCode picks the flags that the next program reports
`timescale 1ns/1ps
module flshc_flash_model import flshc_pkg::*; (
  input wire logic core_clk,
  input wire flshc_pins_t pins,
  input wire logic resetPowerdownN,
  input wire logic [1:0] failCode,
  output logic [FL_DATA_W-1:0] dataOut,
  output logic [FL_DATA_W-1:0] progWord
);
  // flags per failCode: none, data write, supply, protect
  localparam logic [7:0] ERR_TAB [4] = '{8'h00, 8'h10, 8'h18, 8'h02};
  logic [7:0] status; // status byte
  logic statMode; // reads return status
  logic otpArm; // setup code seen
  logic [4:0] busyCnt; // sequencer run time left
  logic weOld; // write strobe one cycle ago
  logic [FL_DATA_W-1:0] lastOut; // last value put on the bus
  // ----------------------------------------
  // command latch and sequencer
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    weOld <= pins.weN;
    if (!resetPowerdownN) begin
      status <= 8'h00;
      statMode <= 1'b0;
      otpArm <= 1'b0;
      busyCnt <= 5'h00;
    end else begin
      if (busyCnt > 5'h01) begin
        busyCnt <= busyCnt - 5'h01;
      end else if (busyCnt == 5'h01 || !status[7]) begin
        busyCnt <= 5'h00;
        // flags only gather, never drop here
        status <= status | 8'h80 | (busyCnt == 5'h01 ? ERR_TAB[failCode] : 8'h00);
      end
      // a command is latched at the end of the write strobe
      if (pins.weN && !weOld && !pins.ceN && busyCnt == 5'h00) begin
        if (otpArm) begin
          progWord <= pins.dataOut;
          otpArm <= 1'b0;
          statMode <= 1'b1;
          busyCnt <= 5'h0c;
          status[7] <= 1'b0;
        end else begin
          case (pins.dataOut[7:0])
            8'hff: statMode <= 1'b0;
            8'h70: statMode <= 1'b1;
            8'h50: status <= status & ~ST_ERR_MASK;
            8'hc0: otpArm <= 1'b1;
            default: status <= status | 8'h30;
          endcase
        end
      end
    end
    if (!pins.ceN && !pins.oeN) lastOut <= dataOut;
  end
  // deselected: show the inverse so a stale value never passes
  always_comb begin
    if (!pins.ceN && !pins.oeN) begin
      dataOut = statMode ? {8'h00, status} : pins.addr[15:0] ^ 16'ha5c3;
    end else begin
      dataOut = ~lastOut;
    end
  end
endmodule

// File: tb/flshc_top_test.sv
// Purpose: self-checking bench of the flash host controller
// Assumes: reset counts shortened to 4 and 2 cycles
// Notes: every wait is bounded and a lapse ends the run
`timescale 1ns/1ps
module flshc_top_test import flshc_pkg::*;;
  localparam logic [7:0] EXP_ST [4] = '{8'h80, 8'h90, 8'h98, 8'h82};
  logic core_clk, reset_n, supplyGood, irq, resetPowerdownN;
  logic [4:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd, w;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp, failCode;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [FL_DATA_W-1:0] flashDataIn, progWord;
  flshc_pins_t flashPins;
  int errors, total_checks;
  flshc_top #(.RST_LOW_CYC(4), .RST_REC_CYC(2)) flshc_top_i (.core_clk, .reset_n, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .supplyGood, .flashDataIn,
    .flashPins, .resetPowerdownN, .irq);
  flshc_flash_model flshc_flash_model_i (.core_clk, .pins(flashPins), .resetPowerdownN, .failCode,
    .dataOut(flashDataIn), .progWord);
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // a wait that ran out of cycles ends the run
  task automatic tmo(input int n);
    if (n >= 200) begin
      chk("wait bound", 32'h0, 32'(n));
      end_sim();
    end
  endtask
  // ----------------------------------------
  // AXI4-Lite master
  // ----------------------------------------
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 200);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    tmo(n);
  endtask
  task automatic rdr(input logic [4:0] a);
    int n;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 200);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    tmo(n);
  endtask
  task automatic waitBit(input logic [4:0] a, input int b, input logic v);
    int n;
    n = 0;
    do begin
      rdr(a);
      n++;
    end while (rd[b] !== v && n < 200);
    tmo(n);
  endtask
  task automatic run(input logic [2:0] op);
    wr(REG_CTRL, {29'h0, op});
    waitBit(REG_CTRL, 0, 1'b0);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, failCode} = '0;
    s_axi_wstrb = 4'hf;
    supplyGood = 1'b1;
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    waitBit(REG_IRQ_STAT, EV_DONE, 1'b1);
    wr(REG_IRQ_MASK, 32'hf);
    wr(REG_IRQ_STAT, 32'hf);
    chk("irq idle", 32'h0, {31'h0, irq});
    wr(REG_IRQ_MASK, 32'h2);
    wr(REG_ADDR, 32'h1234);
    run(OP_READ_ARRAY);
    rdr(REG_RDATA);
    chk("array word", 32'h1234 ^ 32'ha5c3, rd);
    // one-time program with each outcome, then the flags must persist
    for (int i = 0; i < 4; i++) begin
      failCode <= i[1:0];
      w = 32'h5a00 | 32'(i);
      wr(REG_WDATA, w);
      run(OP_OTP_PROGRAM);
      chk("programmed word", w, {16'h0, progWord});
      rdr(REG_STATUS);
      chk("otp status", {21'h0, 1'b1, i != 0, 1'b0, EXP_ST[i]}, rd);
      chk("error irq", {31'h0, i != 0}, {31'h0, irq});
      if (i != 0) begin
        wr(REG_CTRL, {29'h0, OP_OTP_PROGRAM});
        rdr(REG_CTRL);
        chk("retry refused", 32'h0, rd);
      end
      failCode <= 2'h0;
      run(OP_READ_STATUS);
      rdr(REG_STATUS);
      chk("sticky flags", {24'h0, EXP_ST[i]}, {24'h0, rd[7:0]});
      run(OP_CLEAR_STATUS);
      run(OP_READ_STATUS);
      rdr(REG_STATUS);
      chk("cleared flags", 32'h80, {24'h0, rd[7:0]});
      wr(REG_IRQ_STAT, 32'hf);
    end
    // orders that must be refused: bad code, and one while busy
    wr(REG_CTRL, 32'h7);
    wr(REG_CTRL, {29'h0, OP_OTP_PROGRAM});
    wr(REG_CTRL, {29'h0, OP_READ_STATUS});
    waitBit(REG_CTRL, 0, 1'b0);
    rdr(REG_IRQ_STAT);
    chk("refused event", 32'h1, {31'h0, rd[EV_REFUSED]});
    // supply loss while the sequencer runs
    wr(REG_IRQ_STAT, 32'hf);
    wr(REG_CTRL, {29'h0, OP_OTP_PROGRAM});
    repeat (16) @(posedge core_clk);
    supplyGood <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk("reset pin", 32'h0, {31'h0, resetPowerdownN});
    chk("flash status", 32'h0, {24'h0, flshc_flash_model_i.status});
    supplyGood <= 1'b1;
    waitBit(REG_IRQ_STAT, EV_DONE, 1'b1);
    chk("aborted event", 32'h1, {31'h0, rd[EV_ABORTED]});
    run(OP_RESET);
    run(OP_READ_STATUS);
    rdr(REG_STATUS);
    chk("status after reset", 32'h80, {24'h0, rd[7:0]});
    rdr(5'h1c);
    chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
    chk("unmapped data", 32'h0, rd);
    wr(5'h1c, 32'h0);
    chk("unmapped wr resp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
    end_sim();
  end
endmodule
